// file: sysctl_params.svh
// Offsets, field positions, reset values and timing counts of the system control register.
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// Configuration offset of the register (doubleword aligned).
`define SC_OFFSET 8'h80

// Field positions.
`define SC_ROT_HI 31
`define SC_ROT_LO 30
`define SC_TIE_PAIR 29
`define SC_TIE_ALL 28
`define SC_CLK_SRC 27
`define SC_IRQ_ROUTE 26
`define SC_IRQ_FLAG 25
`define SC_IRQ_EN 24
`define SC_RSVD_DRIVE 22
`define SC_PROT_OFF 21
`define SC_BURST_DN 15
`define SC_BURST_UP 14
`define SC_ACTIVITY 13
`define SC_ONE_BIT 12
`define SC_SHIFT_BUSY 11
`define SC_UP_SETTLE 10
`define SC_DN_SETTLE 9
`define SC_PROBE 8
`define SC_LOW_POWER 6
`define SC_ID_LOCK 5

// Reset value and the mask of plain read/write bits.
`define SC_RESET 32'h08449060
`define SC_RW_MASK 32'hfd7fc060

// Internal oscillator: half period in ns and cycles at 8 ns.
`define SC_OSC_HALF_NS 64
`define SC_CLK_NS 8
`define SC_OSC_HALF_CYC (`SC_OSC_HALF_NS / `SC_CLK_NS)

`endif

// file: sysctl_pkg.sv
// Types shared by the system control register and its interrupt mapper.
package sysctl_pkg;
    // Slot rotation code of the serial interrupt stream.
    typedef logic [1:0] rotation_t;
    // One configuration doubleword.
    typedef logic [31:0] word_t;
    // The four interrupt lines, bit 0 is line A.
    typedef logic [3:0] irq_lines_t;
endpackage

// file: irq_slot_mapper.sv
// Ties and rotates the four interrupt lines into serial frame slots.
`timescale 1ns/1ps
module irq_slot_mapper (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Controls.
    input wire sysctl_pkg::rotation_t i_rotation,
    input wire logic i_tie_pair,
    input wire logic i_tie_all,
    // Lines in, slots out.
    input wire sysctl_pkg::irq_lines_t i_lines,
    output sysctl_pkg::irq_lines_t o_slots
);
    // Lines after internal tying.
    sysctl_pkg::irq_lines_t tied;
    // Lines after slot rotation.
    sysctl_pkg::irq_lines_t nxt_slots;
    // Registered slots.
    sysctl_pkg::irq_lines_t slots_ff;

    // Tie-all wins over the pair tie, since it already covers A and B.
    assign tied = i_tie_all ? {3'h0, |i_lines} :
                  i_tie_pair ? {i_lines[3:2], 1'h0,
                                i_lines[1] | i_lines[0]} :
                  i_lines;
    // Each step moves every line one slot later, wrapping round.
    assign nxt_slots = sysctl_pkg::irq_lines_t'({tied, tied}
                       >> (3'h4 - {1'h0, i_rotation}));
    assign o_slots = slots_ff;

    // Register the slots so the serializer sees clean levels.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            slots_ff <= 4'h0;
        end else begin
            slots_ff <= nxt_slots;
        end
    end

    // A lone line A must land in the slot named by the rotation.
    property p_rotation;
        @(posedge i_clk) disable iff (i_rst)
        (!i_tie_all && !i_tie_pair && i_lines == 4'h1)
            |=> (slots_ff == (4'h1 << $past(i_rotation)));
    endproperty
    a_rotation: assert property (p_rotation)
        else $error("slot rotation wrong");
endmodule

// file: sysctl_reg.sv
// System control register of the card bridge, reached by config cycles.
// Notes on behaviour
// - Rotation field shifts interrupt lines into later slots.
// - Pair tie merges lines A and B onto A.
// - Tie-all merges all four lines onto A.
// - Clock source bit picks pin or internal oscillator.
// - Route bit picks legacy IRQ two or status change.
// - Power write with enable sets flag; one clears.
// - Enable makes each power write interrupt; resets off.
// - Bit twelve reads one, bit seven reads zero.
// - Drive reserved pins low while card inserted.
// - Supply protection on when bit zero.
// - Downstream read burst enable, resets on.
// - Upstream read burst enable, resets off.
// - Activity flag set on access, cleared by read.
// - Shift busy from stream start until delay expires.
// - Power-up settling flag until delay expires.
// - Power-down settling flag until delay expires.
// - Probe flag while interrogation runs.
// - Low power mode bit, resets enabled.
// - Identification write lock, resets locked.
// - Global-only bits ignore the bus reset.
// - Context bits keep across bus reset with events.
`timescale 1ns/1ps
`include "sysctl_params.svh"
module sysctl_reg (
    // Clock and resets; i_rst is the global reset.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bus_rst,
    input wire logic i_power_mgmt_event_en,
    // Configuration access port.
    input wire logic [7:0] i_cfg_addr,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [3:0] i_cfg_be,
    input wire sysctl_pkg::word_t i_cfg_wdata,
    output sysctl_pkg::word_t o_cfg_rdata,
    // Socket events from the power switch and card logic.
    input wire logic i_socket_power_wr,
    input wire logic i_socket_access,
    input wire logic i_stream_start,
    input wire logic i_stream_up,
    input wire logic i_stream_sent,
    input wire logic i_delay_expired,
    input wire logic i_probe_start,
    input wire logic i_probe_done,
    input wire logic i_cardbus_inserted,
    // Power change signalling.
    output logic o_legacy_irq_two,
    output logic o_card_status_change,
    // Interrupt lines and the pin-register report.
    input wire sysctl_pkg::irq_lines_t i_irq_lines,
    output sysctl_pkg::irq_lines_t o_irq_slots,
    output logic o_tie_pair_a_b,
    output logic o_tie_all_lines,
    // Power switch clock pin and tick for its state machine.
    input wire logic i_switch_clk_pin,
    output logic o_switch_clk_out,
    output logic o_switch_clk_oe,
    output logic o_switch_tick,
    // Reserved socket terminals, driven low only.
    output logic o_rsvd_pins_out,
    output logic o_rsvd_pins_oe,
    // Plain controls to the rest of the bridge.
    output logic o_supply_protect_off,
    output logic o_read_burst_down,
    output logic o_read_burst_up,
    output logic o_low_power_enable,
    output logic o_id_write_lock
);
    ////////////////////////////////////////////////////////////////////////
    // Decode.

    // Stored read/write bits; other positions stay at zero.
    sysctl_pkg::word_t ctrl_ff;
    sysctl_pkg::word_t nxt_ctrl;
    // Status flags set by hardware.
    logic irq_flag_ff, nxt_irq_flag;
    logic activity_ff, nxt_activity;
    logic shift_busy_ff, nxt_shift_busy;
    logic up_settle_ff, nxt_up_settle;
    logic dn_settle_ff, nxt_dn_settle;
    logic probe_ff, nxt_probe;
    // Bus access decode.
    logic hit, wr_hit, rd_hit;
    sysctl_pkg::word_t lane_mask, wr_mask, rd_word;
    logic flag_clear, activity_clear, context_clear;

    assign hit = (i_cfg_addr == `SC_OFFSET);
    assign wr_hit = hit && i_cfg_wr;
    assign rd_hit = hit && i_cfg_rd;
    assign lane_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                        {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    // Only plain read/write bits in enabled lanes take write data.
    assign wr_mask = wr_hit ? (lane_mask & `SC_RW_MASK) : 32'h0;
    assign nxt_ctrl = (ctrl_ff & ~wr_mask) | (i_cfg_wdata & wr_mask);
    // Reserved bits 20-16 are stored as written; software keeps them.
    assign flag_clear = wr_hit && i_cfg_be[3]
                        && i_cfg_wdata[`SC_IRQ_FLAG];
    assign activity_clear = rd_hit && i_cfg_be[1];
    // Context bits survive the bus reset while events are enabled.
    assign context_clear = i_bus_rst && !i_power_mgmt_event_en;

    ////////////////////////////////////////////////////////////////////////
    // Status flags: a new event wins over a clear, but the bus reset clear of context bits wins over events.

    assign nxt_irq_flag = (i_socket_power_wr && ctrl_ff[`SC_IRQ_EN])
                          || (irq_flag_ff && !flag_clear);
    assign nxt_activity = i_socket_access
                          || (activity_ff && !activity_clear);
    assign nxt_shift_busy = i_stream_start
                            || (shift_busy_ff && !i_delay_expired);
    assign nxt_up_settle = (i_stream_sent && i_stream_up)
                           || (up_settle_ff && !i_delay_expired);
    assign nxt_dn_settle = (i_stream_sent && !i_stream_up)
                           || (dn_settle_ff && !i_delay_expired);
    assign nxt_probe = i_probe_start || (probe_ff && !i_probe_done);

    // Global-only bits: the bus reset has no effect on them.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_ff <= `SC_RESET & `SC_RW_MASK;
            irq_flag_ff <= 1'h0;
            activity_ff <= 1'h0;
            shift_busy_ff <= 1'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            irq_flag_ff <= nxt_irq_flag;
            activity_ff <= nxt_activity;
            shift_busy_ff <= nxt_shift_busy;
        end
    end

    // Context bits: global reset always, bus reset without events.
    always_ff @(posedge i_clk) begin
        if (i_rst || context_clear) begin
            up_settle_ff <= 1'h0;
            dn_settle_ff <= 1'h0;
            probe_ff <= 1'h0;
        end else begin
            up_settle_ff <= nxt_up_settle;
            dn_settle_ff <= nxt_dn_settle;
            probe_ff <= nxt_probe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe.

    // Bit 12 is tied high and bit 7 stays low whatever is written.
    assign rd_word = ctrl_ff
                     | ({31'h0, irq_flag_ff} << `SC_IRQ_FLAG)
                     | ({31'h0, activity_ff} << `SC_ACTIVITY)
                     | (32'h1 << `SC_ONE_BIT)
                     | ({31'h0, shift_busy_ff} << `SC_SHIFT_BUSY)
                     | ({31'h0, up_settle_ff} << `SC_UP_SETTLE)
                     | ({31'h0, dn_settle_ff} << `SC_DN_SETTLE)
                     | ({31'h0, probe_ff} << `SC_PROBE);

    // Unmatched reads return zero so other registers can be ORed in.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg_rdata <= 32'h0;
        end else begin
            o_cfg_rdata <= rd_hit ? rd_word : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power change signalling and plain controls.

    // One pulse per socket power write while enabled, on the chosen path.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_legacy_irq_two <= 1'h0;
            o_card_status_change <= 1'h0;
        end else begin
            o_legacy_irq_two <= i_socket_power_wr && ctrl_ff[`SC_IRQ_EN]
                                && !ctrl_ff[`SC_IRQ_ROUTE];
            o_card_status_change <= i_socket_power_wr
                                    && ctrl_ff[`SC_IRQ_EN]
                                    && ctrl_ff[`SC_IRQ_ROUTE];
        end
    end

    // Controls are copied into output flops; one cycle of lag is harmless.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rsvd_pins_oe <= 1'h0;
            o_supply_protect_off <= 1'h0;
            o_read_burst_down <= 1'h1;
            o_read_burst_up <= 1'h0;
            o_low_power_enable <= 1'h1;
            o_id_write_lock <= 1'h1;
            o_tie_pair_a_b <= 1'h0;
            o_tie_all_lines <= 1'h0;
        end else begin
            o_rsvd_pins_oe <= ctrl_ff[`SC_RSVD_DRIVE]
                              && i_cardbus_inserted;
            o_supply_protect_off <= ctrl_ff[`SC_PROT_OFF];
            o_read_burst_down <= ctrl_ff[`SC_BURST_DN];
            o_read_burst_up <= ctrl_ff[`SC_BURST_UP];
            o_low_power_enable <= ctrl_ff[`SC_LOW_POWER];
            o_id_write_lock <= ctrl_ff[`SC_ID_LOCK];
            o_tie_pair_a_b <= ctrl_ff[`SC_TIE_PAIR];
            o_tie_all_lines <= ctrl_ff[`SC_TIE_ALL];
        end
    end

    // The reserved terminals are only ever pulled low, never driven high.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rsvd_pins_out <= 1'h0;
        end else begin
            o_rsvd_pins_out <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power switch clock.

    // Half-period counter of the internal oscillator.
    logic [7:0] osc_cnt_ff, nxt_osc_cnt;
    logic osc_ff, osc_wrap;
    // Selected switch clock level and its previous value.
    logic sel_clk, sel_prev_ff;

    assign osc_wrap = (osc_cnt_ff == 8'(`SC_OSC_HALF_CYC - 1));
    assign nxt_osc_cnt = osc_wrap ? 8'h0 : osc_cnt_ff + 8'h1;
    // Pin input is already synchronous, so it is used directly.
    assign sel_clk = ctrl_ff[`SC_CLK_SRC] ? osc_ff : i_switch_clk_pin;

    // The tick lets the switch state machine run on this one clock.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= 1'h0;
            sel_prev_ff <= 1'h0;
            o_switch_tick <= 1'h0;
            o_switch_clk_oe <= 1'h0;
            o_switch_clk_out <= 1'h0;
        end else begin
            osc_cnt_ff <= nxt_osc_cnt;
            osc_ff <= osc_wrap ? !osc_ff : osc_ff;
            sel_prev_ff <= sel_clk;
            o_switch_tick <= sel_clk && !sel_prev_ff;
            o_switch_clk_oe <= ctrl_ff[`SC_CLK_SRC];
            o_switch_clk_out <= osc_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt line mapping.

    irq_slot_mapper u_mapper (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_rotation(ctrl_ff[`SC_ROT_HI:`SC_ROT_LO]),
        .i_tie_pair(ctrl_ff[`SC_TIE_PAIR]),
        .i_tie_all(ctrl_ff[`SC_TIE_ALL]),
        .i_lines(i_irq_lines),
        .o_slots(o_irq_slots)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_flag_set;
        @(posedge i_clk) disable iff (i_rst)
        (i_socket_power_wr && ctrl_ff[`SC_IRQ_EN]) |=> irq_flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("power irq flag not set");

    property p_route;
        @(posedge i_clk) disable iff (i_rst)
        (i_socket_power_wr && ctrl_ff[`SC_IRQ_EN])
            |=> (o_card_status_change == $past(ctrl_ff[`SC_IRQ_ROUTE]))
                && (o_legacy_irq_two != o_card_status_change);
    endproperty
    a_route: assert property (p_route)
        else $error("power change routed wrong");

    property p_no_irq_disabled;
        @(posedge i_clk) disable iff (i_rst)
        !ctrl_ff[`SC_IRQ_EN] |=> !o_legacy_irq_two && !o_card_status_change;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled)
        else $error("power irq while disabled");

    property p_fixed_bits;
        @(posedge i_clk) disable iff (i_rst)
        $rose(rd_hit) ##1 1'b1 |-> o_cfg_rdata[12] && !o_cfg_rdata[7];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("fixed reserved bits wrong");

    property p_activity_clear;
        @(posedge i_clk) disable iff (i_rst)
        (activity_clear && !i_socket_access) |=> !activity_ff;
    endproperty
    a_activity_clear: assert property (p_activity_clear)
        else $error("activity not cleared by read");

    property p_busy_hold;
        @(posedge i_clk) disable iff (i_rst)
        (shift_busy_ff && !i_delay_expired) |=> shift_busy_ff;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("shift busy dropped early");

    property p_up_settle;
        @(posedge i_clk) disable iff (i_rst || context_clear)
        (i_stream_sent && i_stream_up) |=> up_settle_ff && !dn_settle_ff
            || $past(dn_settle_ff) && !$past(i_delay_expired);
    endproperty
    a_up_settle: assert property (p_up_settle)
        else $error("power-up settling flag wrong");

    property p_probe_done;
        @(posedge i_clk) disable iff (i_rst)
        (i_probe_done && !i_probe_start) |=> !probe_ff;
    endproperty
    a_probe_done: assert property (p_probe_done)
        else $error("probe flag not cleared");

    property p_lane_guard;
        @(posedge i_clk) disable iff (i_rst)
        (wr_hit && !i_cfg_be[1]) |=> ctrl_ff[15:8] == $past(ctrl_ff[15:8]);
    endproperty
    a_lane_guard: assert property (p_lane_guard)
        else $error("disabled byte lane written");

    property p_bus_rst_keep;
        @(posedge i_clk) disable iff (i_rst)
        (i_bus_rst && !wr_hit) |=> $stable(ctrl_ff);
    endproperty
    a_bus_rst_keep: assert property (p_bus_rst_keep)
        else $error("bus reset touched global bits");

    property p_rsvd_drive;
        @(posedge i_clk) disable iff (i_rst)
        (ctrl_ff[`SC_RSVD_DRIVE] && i_cardbus_inserted)
            |=> o_rsvd_pins_oe && !o_rsvd_pins_out;
    endproperty
    a_rsvd_drive: assert property (p_rsvd_drive)
        else $error("reserved pins not driven low");
endmodule

// file: cfg_host_model.sv
// Host model that issues configuration reads and writes to the register.
`timescale 1ns/1ps
`include "sysctl_params.svh"
module cfg_host_model (
    // Clock.
    input wire logic i_clk,
    // Configuration port toward the register.
    output logic [7:0] o_cfg_addr,
    output logic o_cfg_wr,
    output logic o_cfg_rd,
    output logic [3:0] o_cfg_be,
    output sysctl_pkg::word_t o_cfg_wdata,
    // Registered read data.
    input wire sysctl_pkg::word_t i_cfg_rdata
);
    // Idle bus at time zero.
    initial begin
        o_cfg_addr = 8'h00;
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_be = 4'h0;
        o_cfg_wdata = 32'h00000000;
    end

    // One access: set after an edge, held over the taking edge, then
    // released. Released fields flip so no stale value looks valid.
    task automatic access(input logic is_wr, input logic [7:0] a,
            input logic [3:0] be, input sysctl_pkg::word_t d,
            output sysctl_pkg::word_t q);
        @(posedge i_clk);
        #1;
        o_cfg_wr = is_wr;
        o_cfg_rd = ~is_wr;
        o_cfg_addr = a;
        o_cfg_be = be;
        o_cfg_wdata = d;
        @(posedge i_clk);
        #1;
        q = i_cfg_rdata;
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_addr = ~o_cfg_addr;
        o_cfg_wdata = ~o_cfg_wdata;
    endtask

    // Read-modify-write. Reserved bits keep their value and the
    // write-one-to-clear flag is written as zero so it is not lost.
    task automatic rmw(input sysctl_pkg::word_t m,
            input sysctl_pkg::word_t v);
        sysctl_pkg::word_t q;
        sysctl_pkg::word_t n;
        access(1'b0, `SC_OFFSET, 4'hf, 32'h0, q);
        n = (q & ~m & ~32'h02000000) | (v & m);
        access(1'b1, `SC_OFFSET, 4'hf, n, q);
    endtask
endmodule

// file: testbench.sv
// Self-checking bench of the system control register.
`timescale 1ns/1ps
`include "sysctl_params.svh"
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic event_en = 1'b0;
    logic [7:0] ev = 8'h00; // Event pulses, one bit per input.
    logic up = 1'b0;
    logic inserted = 1'b0;
    logic pin = 1'b0;
    sysctl_pkg::irq_lines_t lines = 4'h0;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [3:0] be;
    sysctl_pkg::word_t wdata;
    sysctl_pkg::word_t rdata;
    sysctl_pkg::irq_lines_t slots;
    logic legacy_irq, status_irq, tpair, tall, sck, sck_oe, tick, rpo, rpoe;
    logic prot_off, bdn, bup, lowp, idlk;
    int n_errors = 0;
    int n_tests = 0;
    int ticks = 0;

    // Clock at 125 MHz; external switch clock with a period of 8 cycles.
    always #4 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #1;
        pin = ~pin;
    end

    // Counts switch ticks so the selected clock rate can be measured.
    always @(posedge clk) begin
        if (tick === 1'b1) begin
            ticks <= ticks + 1;
        end
    end

    cfg_host_model host (.i_clk(clk), .o_cfg_addr(addr), .o_cfg_wr(wr),
        .o_cfg_rd(rd), .o_cfg_be(be), .o_cfg_wdata(wdata),
        .i_cfg_rdata(rdata));

    sysctl_reg dut (.i_clk(clk), .i_rst(rst), .i_bus_rst(ev[7]),
        .i_power_mgmt_event_en(event_en), .i_cfg_addr(addr),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_be(be),
        .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
        .i_socket_power_wr(ev[0]), .i_socket_access(ev[1]),
        .i_stream_start(ev[2]), .i_stream_up(up),
        .i_stream_sent(ev[3]), .i_delay_expired(ev[4]),
        .i_probe_start(ev[5]), .i_probe_done(ev[6]),
        .i_cardbus_inserted(inserted), .o_legacy_irq_two(legacy_irq),
        .o_card_status_change(status_irq), .i_irq_lines(lines),
        .o_irq_slots(slots), .o_tie_pair_a_b(tpair),
        .o_tie_all_lines(tall), .i_switch_clk_pin(pin),
        .o_switch_clk_out(sck), .o_switch_clk_oe(sck_oe),
        .o_switch_tick(tick), .o_rsvd_pins_out(rpo),
        .o_rsvd_pins_oe(rpoe), .o_supply_protect_off(prot_off),
        .o_read_burst_down(bdn), .o_read_burst_up(bup),
        .o_low_power_enable(lowp), .o_id_write_lock(idlk));

    ////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                $time, what, seen, exp);
        end
    endtask

    task automatic rd_reg(output sysctl_pkg::word_t q);
        host.access(1'b0, `SC_OFFSET, 4'hf, 32'h0, q);
    endtask

    // One-cycle pulse on an event input, launched after an edge.
    task automatic pulse(input int i);
        @(posedge clk);
        #1;
        ev[i] = 1'b1;
        @(posedge clk);
        #1;
        ev[i] = 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_fields();
        sysctl_pkg::word_t q;
        rd_reg(q);
        check(q, `SC_RESET, "reset value");
        check({bdn, bup, prot_off, lowp, idlk, sck_oe}, 6'b100111,
            "reset outputs");
        host.rmw(32'hfd60c060, 32'hfd60c060);
        rd_reg(q);
        check(q, 32'hfd64d060, "all controls set");
        check({bdn, bup, prot_off, lowp, idlk}, 5'h1f, "set outs");
        host.rmw(32'hfd60c060, 32'h0);
        rd_reg(q);
        check(q, 32'h00041000, "all controls clear");
        check({bdn, bup, prot_off, lowp, idlk, sck_oe}, 6'h00,
            "clear outs");
        host.access(1'b1, `SC_OFFSET, 4'h2, 32'hffffffff, q);
        rd_reg(q);
        check(q, 32'h0004d000, "one lane, status ignored");
        host.access(1'b1, 8'h84, 4'hf, 32'hffffffff, q);
        host.access(1'b0, 8'h84, 4'hf, 32'h0, q);
        check(q, 32'h0, "unmapped read");
        rd_reg(q);
        check(q, 32'h0004d000, "unmapped write ignored");
        host.rmw(32'hfd60c060, `SC_RESET);
    endtask

    // Power write signalling through both routes, then disabled.
    task automatic t_power_irq();
        sysctl_pkg::word_t q;
        for (int r = 0; r < 2; r++) begin
            host.rmw(32'h05000000, r ? 32'h05000000 : 32'h01000000);
            pulse(0);
            check({legacy_irq, status_irq}, r ? 2'b01 : 2'b10,
                "route pulse");
            @(posedge clk);
            #1;
            check({legacy_irq, status_irq}, 2'b00, "one pulse only");
            rd_reg(q);
            check(q[25], 1'b1, "flag set");
            host.access(1'b1, `SC_OFFSET, 4'h8, q | 32'h02000000, q);
            rd_reg(q);
            check(q[25], 1'b0, "flag cleared by one");
        end
        host.rmw(32'h05000000, 32'h0);
        pulse(0);
        check({legacy_irq, status_irq}, 2'b00, "disabled no pulse");
        rd_reg(q);
        check(q[25], 1'b0, "disabled no flag");
    endtask

    // Activity, stream, settling and probe flags, then bus reset.
    task automatic t_status();
        sysctl_pkg::word_t q;
        pulse(1);
        rd_reg(q);
        check(q[13], 1'b1, "activity set");
        rd_reg(q);
        check(q[13], 1'b0, "activity read clear");
        pulse(2);
        rd_reg(q);
        check(q[11:8], 4'h8, "stream busy");
        up = 1'b1;
        pulse(3);
        rd_reg(q);
        check(q[11:8], 4'hc, "power-up settling");
        pulse(4);
        rd_reg(q);
        check(q[11:8], 4'h0, "delay over");
        up = 1'b0;
        pulse(3);
        rd_reg(q);
        check(q[11:8], 4'h2, "power-down settling");
        pulse(4);
        pulse(5);
        rd_reg(q);
        check(q[11:8], 4'h1, "probe running");
        pulse(6);
        rd_reg(q);
        check(q[11:8], 4'h0, "probe done");
        event_en = 1'b1;
        up = 1'b1;
        pulse(2);
        pulse(3);
        pulse(5);
        pulse(7);
        rd_reg(q);
        check(q[11:8], 4'hd, "context kept with events");
        event_en = 1'b0;
        pulse(7);
        rd_reg(q);
        check(q[11:8], 4'h8, "context cleared");
        check(q & 32'hfffff0ff, `SC_RESET, "controls kept");
    endtask

    // Slot rotation for every code, then the two tie modes.
    task automatic t_irq_map();
        lines = 4'b0001;
        for (int r = 0; r < 4; r++) begin
            host.rmw(32'hf0000000, 32'(r) << 30);
            settle();
            check(slots, 4'b0001 << r, "rotation");
        end
        host.rmw(32'hf0000000, 32'h20000000);
        lines = 4'b0010;
        settle();
        check({tpair, slots}, 5'h11, "pair tie B onto A");
        lines = 4'b0100;
        settle();
        check(slots, 4'b0100, "pair tie leaves C");
        host.rmw(32'hf0000000, 32'h10000000);
        lines = 4'b1000;
        settle();
        check({tall, slots}, 5'h11, "tie all onto A");
        host.rmw(32'hf0000000, 32'h0);
    endtask

    // Switch clock rate for both sources, and reserved terminals.
    task automatic t_pins();
        int c;
        c = ticks;
        repeat (64) @(posedge clk);
        #1;
        check(ticks - c, 4, "oscillator ticks");
        c = sck;
        repeat (8) @(posedge clk);
        #1;
        check(sck, !c, "oscillator drives pin");
        host.rmw(32'h08000000, 32'h0);
        repeat (8) @(posedge clk);
        #1;
        c = ticks;
        repeat (64) @(posedge clk);
        #1;
        check(ticks - c, 8, "pin ticks");
        host.rmw(32'h08000000, 32'h08000000);
        inserted = 1'b1;
        settle();
        check({rpoe, rpo}, 2'b10, "terminals driven low");
        host.rmw(32'h00400000, 32'h0);
        settle();
        check(rpoe, 1'b0, "terminals released");
        host.rmw(32'h00400000, 32'h00400000);
        inserted = 1'b0;
        settle();
        check(rpoe, 1'b0, "no card, released");
    endtask

    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_fields();
        t_power_irq();
        t_status();
        t_irq_map();
        t_pins();
        finish_test();
    end

    // Watchdog well beyond the few hundred cycles the run needs.
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
endmodule
